// [hdl/pcrb_pkg.sv]
// Package for the pad configuration register bank.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package pcrb_pkg;
   localparam int unsigned NUM_PINS = 11;
   localparam int unsigned ADDR_W   = 32;
   localparam int unsigned DATA_W   = 32;

   // Byte addresses of each pin word, in table order
   localparam logic [31:0] PCRB_BASE = 32'h4004_4000;
   localparam logic [31:0] OFF_PIN_TWELVE  = 32'h4004_4008;
   localparam logic [31:0] OFF_PIN_FIVE    = 32'h4004_400c;
   localparam logic [31:0] OFF_PIN_FOUR    = 32'h4004_4010;
   localparam logic [31:0] OFF_PIN_THREE   = 32'h4004_4014;
   localparam logic [31:0] OFF_PIN_TWO     = 32'h4004_4018;
   localparam logic [31:0] OFF_PIN_ELEVEN  = 32'h4004_401c;
   localparam logic [31:0] OFF_PIN_TEN     = 32'h4004_4020;
   localparam logic [31:0] OFF_PIN_SIXTEEN = 32'h4004_4024;
   localparam logic [31:0] OFF_PIN_FIFTEEN = 32'h4004_4028;
   localparam logic [31:0] OFF_PIN_ONE     = 32'h4004_402c;
   localparam logic [31:0] OFF_PIN_NINE    = 32'h4004_4034;

   localparam logic [NUM_PINS*32-1:0] PIN_OFFSETS = {
      OFF_PIN_NINE, OFF_PIN_ONE, OFF_PIN_FIFTEEN, OFF_PIN_SIXTEEN,
      OFF_PIN_TEN, OFF_PIN_ELEVEN, OFF_PIN_TWO, OFF_PIN_THREE,
      OFF_PIN_FOUR, OFF_PIN_FIVE, OFF_PIN_TWELVE};

   // Field positions
   localparam int unsigned PULL_LSB = 3;
   localparam int unsigned PULL_MSB = 4;
   localparam int unsigned HYS_BIT  = 5;
   localparam int unsigned INV_BIT  = 6;
   localparam int unsigned RSV_LSB  = 7;
   localparam int unsigned RSV_MSB  = 9;
   localparam int unsigned POD_BIT  = 10;

   // Pull codes
   typedef enum logic [1:0] {
      PCRB_PULL_NONE = 2'h0,
      PCRB_PULL_DOWN = 2'h1,
      PCRB_PULL_UP   = 2'h2,
      PCRB_PULL_RPT  = 2'h3
   } pcrb_pull_e;

   // Reset values
   localparam logic [1:0] PULL_RST = 2'h2;
   localparam logic       HYS_RST  = 1'h1;
   localparam logic       INV_RST  = 1'h0;
   localparam logic       POD_RST  = 1'h0;
   localparam logic [2:0] RSV_FIXED = 3'h1;
   localparam logic [31:0] WORD_RST = 32'h0000_00b0;
endpackage : pcrb_pkg

// [hdl/pcrb_pad_ctl.sv]
// One pin's pad control: pull resistors, repeater hold and input inversion.
// Assumes the pin level is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pcrb_pad_ctl (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Configuration
   input  wire logic [1:0] pull_i,
   input  wire logic       inv_i,
   // Pad
   input  wire logic       pin_i,
   output var  logic       pu_en_o,
   output var  logic       pd_en_o,
   output var  logic       pin_rd_o
);
   pcrb_pkg::pcrb_pull_e mode;
   assign mode = pcrb_pkg::pcrb_pull_e'(pull_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pu_en_o <= 1'b1;
         pd_en_o <= 1'b0;
      end else begin
         unique case (mode)
            pcrb_pkg::PCRB_PULL_NONE: begin
               pu_en_o <= 1'b0;
               pd_en_o <= 1'b0;
            end
            pcrb_pkg::PCRB_PULL_DOWN: begin
               pu_en_o <= 1'b0;
               pd_en_o <= 1'b1;
            end
            pcrb_pkg::PCRB_PULL_UP: begin
               pu_en_o <= 1'b1;
               pd_en_o <= 1'b0;
            end
            pcrb_pkg::PCRB_PULL_RPT: begin
               // Follow the pin so an undriven input keeps its level
               pu_en_o <= pin_i;
               pd_en_o <= ~pin_i;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) pin_rd_o <= 1'b0;
      else pin_rd_o <= pin_i ^ inv_i;
   end

   inv_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 !$past(rst_i) |-> pin_rd_o == ($past(pin_i) ^ $past(inv_i)))
      else $error("inverted read mismatch");
   pull_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pull_i == 2'h0 |=> !pu_en_o && !pd_en_o)
      else $error("pull enabled while inactive");
   rpt_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pull_i == 2'h3 |=> pu_en_o == $past(pin_i) && pd_en_o != pu_en_o)
      else $error("repeater does not follow pin");
endmodule // pcrb_pad_ctl
`default_nettype wire

// [hdl/pcrb_top.sv]
// Pad configuration register bank with a classic Wishbone slave port.
// Assumes a single-cycle-per-request Wishbone master on clk_i.
//
// Behaviour
// - Each pin word has a two-bit pull field at bits 4:3 that resets to pull-up.
// - Pull code zero enables no resistor and code one only the pull-down.
// - With the invert bit 6 clear (its reset value) a high pin reads as one.
// - With the invert bit set the sampled input is complemented.
// - Bit 10 selects pseudo open-drain output, clear after reset.
// - Repeater code pulls up while the pin is high and down while low.
`timescale 1ns/1ps
`default_nettype none
module pcrb_top #(
   parameter int unsigned NUM_PINS = pcrb_pkg::NUM_PINS
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [31:0]         adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output var  logic [31:0]         dat_o,
   output var  logic                ack_o,
   // Pads
   input  wire logic [NUM_PINS-1:0] pin_i,
   output var  logic [NUM_PINS-1:0] pu_en_o,
   output var  logic [NUM_PINS-1:0] pd_en_o,
   output var  logic [NUM_PINS-1:0] hys_en_o,
   output var  logic [NUM_PINS-1:0] pod_en_o,
   output var  logic [NUM_PINS-1:0] pin_rd_o
);
   if (NUM_PINS != pcrb_pkg::NUM_PINS) begin : g_chk
      $error("pcrb_top: NUM_PINS must match the register map");
   end

   logic [1:0]          pull [NUM_PINS];
   logic [NUM_PINS-1:0] hysteresis_enable;
   logic [NUM_PINS-1:0] input_invert;
   logic [NUM_PINS-1:0] pod;
   logic [NUM_PINS-1:0] hit;
   logic                req;
   logic                wr_go;
   logic [31:0]         next_dat;

   // Accept only while no ack is out, so each request is taken once
   assign req   = cyc_i && stb_i && !ack_o;
   assign wr_go = req && we_i;

   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      assign hit[p] = adr_i == pcrb_pkg::PIN_OFFSETS[p*32 +: 32];

      // Byte lane 0 holds pull, hys, inv; lane 1 holds the open-drain bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pull[p] <= pcrb_pkg::PULL_RST;
            hysteresis_enable[p]  <= pcrb_pkg::HYS_RST;
            input_invert[p]  <= pcrb_pkg::INV_RST;
         end else if (wr_go && hit[p] && sel_i[0]) begin
            pull[p] <= dat_i[pcrb_pkg::PULL_MSB:pcrb_pkg::PULL_LSB];
            hysteresis_enable[p]  <= dat_i[pcrb_pkg::HYS_BIT];
            input_invert[p]  <= dat_i[pcrb_pkg::INV_BIT];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) pod[p] <= pcrb_pkg::POD_RST;
         else if (wr_go && hit[p] && sel_i[1])
            pod[p] <= dat_i[pcrb_pkg::POD_BIT];
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            hys_en_o[p] <= pcrb_pkg::HYS_RST;
            pod_en_o[p] <= pcrb_pkg::POD_RST;
         end else begin
            hys_en_o[p] <= hysteresis_enable[p];
            pod_en_o[p] <= pod[p];
         end
      end

      pcrb_pad_ctl u_pad (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .pull_i   (pull[p]),
         .inv_i    (input_invert[p]),
         .pin_i    (pin_i[p]),
         .pu_en_o  (pu_en_o[p]),
         .pd_en_o  (pd_en_o[p]),
         .pin_rd_o (pin_rd_o[p])
      );
   end

   // Read mux; unmapped addresses read zero and are still acknowledged
   always_comb begin
      next_dat = 32'h0000_0000;
      for (int p = 0; p < NUM_PINS; p++) begin
         if (hit[p]) begin
            next_dat[pcrb_pkg::PULL_MSB:pcrb_pkg::PULL_LSB] = pull[p];
            next_dat[pcrb_pkg::HYS_BIT] = hysteresis_enable[p];
            next_dat[pcrb_pkg::INV_BIT] = input_invert[p];
            next_dat[pcrb_pkg::RSV_MSB:pcrb_pkg::RSV_LSB] =
               pcrb_pkg::RSV_FIXED;
            next_dat[pcrb_pkg::POD_BIT] = pod[p];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) ack_o <= 1'b0;
      else ack_o <= req;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) dat_o <= 32'h0000_0000;
      else if (req && !we_i) dat_o <= next_dat;
   end

   sequence wb_read_s;
      req && !we_i && hit[0];
   endsequence

   ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> ack_o ##1 !ack_o)
      else $error("ack not one cycle after request");
   reset_word_a: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> pull[0] == 2'h2 && hysteresis_enable[0] && !input_invert[0]
      && !pod[0])
      else $error("pin word not at reset value");
   rsv_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_read_s |=> dat_o[9:7] == 3'h1 && dat_o[31:11] == 21'h0
      && dat_o[2:0] == 3'h0)
      else $error("reserved bits read wrong");
   pod_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_go && hit[0] && sel_i[1] |=> ##1 pod_en_o[0] == $past(dat_i[10], 2))
      else $error("open-drain bit not applied");
   pull_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_go && hit[0] && sel_i[0] |=> pull[0] == $past(dat_i[4:3]))
      else $error("pull field not written");
   inv_reset_a: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> !input_invert[0] ##1 (pin_rd_o[0] == $past(pin_i[0])))
      else $error("input inverted after reset");
endmodule // pcrb_top
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the pad configuration register bank.
// Assumes a Wishbone answer one cycle after a request, pads one cycle late.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int NP = pcrb_pkg::NUM_PINS;
   logic          clk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          cyc_i = 1'b0;
   logic          stb_i = 1'b0;
   logic          we_i  = 1'b0;
   logic [31:0]   adr_i = 32'h0000_0000;
   logic [3:0]    sel_i = 4'h0;
   logic [31:0]   dat_i = 32'h0000_0000;
   logic [NP-1:0] pin_i = 11'h555;
   logic [31:0]   dat_o;
   logic          ack_o;
   logic [NP-1:0] pu_en_o;
   logic [NP-1:0] pd_en_o;
   logic [NP-1:0] hys_en_o;
   logic [NP-1:0] pod_en_o;
   logic [NP-1:0] pin_rd_o;
   logic [31:0]   rd;
   int            error_cnt = 0;
   int            comparisons = 0;

   always #12.5 clk_i = ~clk_i;

   pcrb_top #(.NUM_PINS(NP)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i), .pu_en_o(pu_en_o),
      .pd_en_o(pd_en_o), .hys_en_o(hys_en_o), .pod_en_o(pod_en_o),
      .pin_rd_o(pin_rd_o));

   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Read data is taken at the very edge that samples ack high
   task automatic wb(input logic [31:0] a, input logic w,
                     input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      if (n >= 50) begin
         error_cnt++;
         $display("[FAIL] %0t no acknowledge", $time);
         report_and_stop();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic check_word(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t word %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_pads(input logic [NP-1:0] g, input logic [NP-1:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t pads %h expected %h", $time, g, e);
      end
   endtask

   function automatic logic [31:0] adr_of(input int i);
      return pcrb_pkg::PIN_OFFSETS[i*32 +: 32];
   endfunction

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check_pads(pu_en_o, '1);
      check_pads(pd_en_o, '0);
      check_pads(hys_en_o, '1);
      check_pads(pod_en_o, '0);
      // Pin read still shows its reset zero here; it lags by one cycle
      @(posedge clk_i);
      check_pads(pin_rd_o, pin_i);
      for (int i = 0; i < NP; i++) begin
         wb(adr_of(i), 1'b0, 4'hf, 32'h0000_0000);
         check_word(rd, 32'h0000_00b0);
      end
      // Unmapped hole: write ignored, reads zero
      wb(32'h4004_4030, 1'b1, 4'hf, 32'hffff_ffff);
      wb(32'h4004_4030, 1'b0, 4'hf, 32'h0000_0000);
      check_word(rd, 32'h0000_0000);
      for (int i = 0; i < NP; i++) begin
         wb(adr_of(i), 1'b1, 4'hf, 32'hffff_ffff);
         wb(adr_of(i), 1'b0, 4'hf, 32'h0000_0000);
         check_word(rd, 32'h0000_04f8);
      end
      // Repeater must follow the pin both ways
      for (int k = 0; k < 2; k++) begin
         pin_i <= k ? 11'h2aa : 11'h555;
         repeat (3) @(posedge clk_i);
         check_pads(pu_en_o, pin_i);
         check_pads(pd_en_o, ~pin_i);
         check_pads(pin_rd_o, ~pin_i);
         check_pads(pod_en_o, '1);
         check_pads(hys_en_o, '1);
      end
      for (int c = 0; c < 3; c++) begin
         for (int i = 0; i < NP; i++) begin
            wb(adr_of(i), 1'b1, 4'hf, 32'(c) << 3);
            wb(adr_of(i), 1'b0, 4'hf, 32'h0000_0000);
            check_word(rd, 32'h0000_0080 | (32'(c) << 3));
         end
         repeat (3) @(posedge clk_i);
         check_pads(pu_en_o, (c == 2) ? '1 : '0);
         check_pads(pd_en_o, (c == 1) ? '1 : '0);
         check_pads(pin_rd_o, pin_i);
         check_pads(pod_en_o, '0);
         check_pads(hys_en_o, '0);
      end
      // Byte lanes: low lane leaves bit 10 alone, lane one sets it
      wb(adr_of(3), 1'b1, 4'h1, 32'hffff_ffff);
      wb(adr_of(3), 1'b0, 4'hf, 32'h0000_0000);
      check_word(rd, 32'h0000_00f8);
      wb(adr_of(3), 1'b1, 4'h2, 32'h0000_0400);
      wb(adr_of(3), 1'b0, 4'hf, 32'h0000_0000);
      check_word(rd, 32'h0000_04f8);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
